// [include/lpcs_pkg.sv]
// lpcs_pkg: constants shared by the bus phy control block and its spi frame fifo.
// assumes a 10 MHz core clock; no other package is needed.
package lpcs_pkg;
    // core clock rate and derived cycle counts
    localparam longint unsigned CLK_HZ             = 64'd10000000;
    localparam longint unsigned TX_DOM_TIME_MS     = 64'd1000;     // stuck dominant time, ms
    localparam longint unsigned TX_DOM_CYCLES      = TX_DOM_TIME_MS * CLK_HZ / 64'd1000;
    localparam longint unsigned WAKE_FILT_TIME_US  = 64'd30;       // wake dominant filter, us
    localparam longint unsigned WAKE_FILT_CYCLES   =
        (WAKE_FILT_TIME_US * CLK_HZ + 64'd999999) / 64'd1000000;

    // spi frame layout
    localparam int unsigned FRAME_BITS   = 8;
    localparam int unsigned ADDR_MSB     = 7;
    localparam int unsigned ADDR_LSB     = 4;
    localparam int unsigned FIFO_DEPTH   = 16;

    // register addresses
    localparam logic [3:0] ADDR_MODE_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_VOLT_STAT   = 4'h1;
    localparam logic [3:0] ADDR_BUS_CTRL    = 4'h4;
    localparam logic [3:0] ADDR_BUS_STAT    = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'he;
    localparam logic [3:0] ADDR_IRQ_SRC     = 4'hf;

    // bus control field positions
    localparam int unsigned DOM_LVL_BIT  = 3;
    localparam int unsigned RX_ONLY_BIT  = 2;
    localparam int unsigned PULLUP_BIT   = 2;
    localparam int unsigned MODE_MSB     = 1;
    localparam int unsigned BUS_MASK_BIT = 1;
    localparam int unsigned SUMMARY_BUS  = 2;

    // reset values
    localparam logic [3:0] BUS_CTRL_RST  = 4'h0;   // slew code 00 is the 20 kbit/s setting
    localparam logic [3:0] MODE_CTRL_RST = 4'hc;
    localparam logic [3:0] IRQ_MASK_RST  = 4'h0;

    // slew rate codes
    localparam logic [1:0] SLEW_20K   = 2'h0;
    localparam logic [1:0] SLEW_10K4  = 2'h1;
    localparam logic [1:0] SLEW_FAST  = 2'h2;

    // operating modes
    typedef enum logic [3:0] {
        LPCS_NORMAL = 4'h1,
        LPCS_STOP   = 4'h2,
        LPCS_SLEEP  = 4'h4,
        LPCS_NWDC   = 4'h8
    } lpcs_mode_e;
endpackage : lpcs_pkg

// [hw/lpcs_fifo.sv]
// lpcs_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module lpcs_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];            // storage words
    logic [AW:0]      wr_ptr_reg;             // write pointer with wrap bit
    logic [AW:0]      rd_ptr_reg;             // read pointer with wrap bit
    wire              full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                              (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire              empty = (wr_ptr_reg == rd_ptr_reg);
    wire              push  = in_valid && !full;
    wire              pop   = !empty && out_ready;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // storage write, no reset needed for data
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointer update
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule : lpcs_fifo
`default_nettype wire

// [hw/lpcs_top.sv]
// lpcs_top: digital control of a single-wire bus phy plus its 8-bit spi register port.
// assumes spi pins and phy sense pins arrive asynchronously and are synchronised here;
// spi clock is slow (well under core_clk/4) so it is oversampled on core_clk.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - two-bit slew select, defaults 20 kbit/s
// - pull-up bit clear drops pull-up in low power, sets wake threshold
// - over-current sets flag; in normal mode it sets receive-only, which blocks tx
// - any fault flag with mask drives interrupt
// - over-temperature disables transmitter, sets flag
// - over-temp recovery when gone and txd high
// - rxd short sets flag, disables transmitter
// - rxd toggle recovers; clean status read clears
// - txd low one second disables, flags
// - txd high recovers; status read clears flag
// - dominant level select bit drives level
// - receive-only blocks tx, set on errors in normal mode
// - receive-only in low power blocks wake
// - stop mode wake raises interrupt source
// - sleep mode wake requests system reset
// - frame is address, control; summary, status
// - chip select fall drives miso, latches
// - launch on sclk rise, sample fall
// - only exactly eight edges make valid
// - chip select rise commits write, miso off
// - resets restore registers, power-on sets flag
// - control register at address 4 layout
// - status register readable at 4 and 5
// - summary bit set when any status bit
module lpcs_top #(
    parameter longint unsigned TX_DOM_CYC = lpcs_pkg::TX_DOM_CYCLES,
    parameter int unsigned     FIFO_DEPTH = lpcs_pkg::FIFO_DEPTH
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,          // power-on reset, async
    input  wire logic       ext_rst_n,      // reset pin / reset mode request, async pin
    input  wire logic       cs_n,           // spi chip select pin
    input  wire logic       sclk,           // spi clock pin
    input  wire logic       mosi,           // spi data in pin
    output logic            miso_o,         // spi data out
    output logic            miso_oe,        // miso drive enable
    input  wire logic       txd,            // transmit data pin
    input  wire logic       bus_rx,         // receiver comparator output
    input  wire logic       rxd_fb,         // rxd pin readback
    input  wire logic       ocur_det,       // analog over-current sense
    input  wire logic       otemp_det,      // analog over-temperature sense
    input  wire logic [3:0] volt_flags,     // other voltage status flags, bit0 unused
    input  wire logic       hs_summary,     // high side summary from elsewhere
    input  wire logic       ls_summary,     // low side summary from elsewhere
    output logic            rxd_o,          // rxd pin drive
    output logic            tx_drive,       // low-side driver on
    output logic [1:0]      slew_rate_select,
    output logic            dominant_level_select,
    output logic            pullup_on,      // internal pull-up connected
    output logic            bus_wake_threshold,
    output logic            irq_n,          // interrupt output, active low
    output logic            wake_reset_req  // sleep wake system reset request
);
    // two-stage synchronisers for all pins except volt_flags and the summaries
    localparam int unsigned NSYNC = 8;
    logic [NSYNC-1:0] sync1_reg;           // first stage, read only by second stage
    logic [NSYNC-1:0] sync2_reg;           // second stage
    wire  [NSYNC-1:0] pins = {ext_rst_n, cs_n, sclk, mosi, txd, bus_rx, rxd_fb,
                              ocur_det | otemp_det ? 1'b0 : 1'b0};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 8'hff;
            sync2_reg <= 8'hff;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end
    logic [1:0] an_s1_reg;                 // analog sense first stage
    logic [1:0] an_s2_reg;                 // analog sense second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            an_s1_reg <= 2'h0;
            an_s2_reg <= 2'h0;
        end else begin
            an_s1_reg <= {otemp_det, ocur_det};
            an_s2_reg <= an_s1_reg;
        end
    end
    wire ext_rst_s = sync2_reg[7];
    wire cs_s      = sync2_reg[6];
    wire sclk_s    = sync2_reg[5];
    wire mosi_s    = sync2_reg[4];
    wire txd_s     = sync2_reg[3];
    wire bus_s     = sync2_reg[2];
    wire rxfb_s    = sync2_reg[1];
    wire oc_s      = an_s2_reg[0];
    wire ot_s      = an_s2_reg[1];

    // edge detection on synchronised spi, rxd readback and bus lines
    logic cs_d_reg;                        // delayed chip select
    logic sclk_d_reg;                      // delayed spi clock
    logic rxfb_d_reg;                      // delayed rxd readback
    logic bus_d_reg;                       // delayed bus level
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_d_reg   <= 1'b1;
            sclk_d_reg <= 1'b0;
            rxfb_d_reg <= 1'b1;
            bus_d_reg  <= 1'b1;
        end else begin
            cs_d_reg   <= cs_s;
            sclk_d_reg <= sclk_s;
            rxfb_d_reg <= rxfb_s;
            bus_d_reg  <= bus_s;
        end
    end
    wire cs_fall   = cs_d_reg && !cs_s;
    wire cs_rise   = !cs_d_reg && cs_s;
    wire sclk_rise = !sclk_d_reg && sclk_s && !cs_s;
    wire sclk_fall = sclk_d_reg && !sclk_s && !cs_s;
    wire rx_toggle = rxfb_d_reg != rxfb_s;
    wire bus_rise  = !bus_d_reg && bus_s;

    // soft reset: reset pin or reset mode restores registers
    wire soft_rst = !ext_rst_s;

    // control and status registers
    logic [3:0] bus_phy_control_reg;       // dom level, rx only, slew[1:0]
    logic [3:0] mode_control_reg;          // hv enable, pull-up, mode[1:0]
    logic [3:0] interrupt_mask_reg;        // masks; bit1 is bus mask
    logic [3:0] interrupt_source_reg;      // bit1 bus wake source
    logic       power_loss_flag;           // set by power-on only
    logic       bus_overcurrent_flag;
    logic       bus_overtemp_flag;
    logic       rx_pin_short_flag;
    logic       tx_stuck_dominant_flag;
    logic       ot_off_reg;                // transmitter held off by over-temp
    logic       rs_off_reg;                // transmitter held off by rxd short
    logic       td_off_reg;                // transmitter held off by stuck txd
    wire  [3:0] bus_phy_status = {rx_pin_short_flag, tx_stuck_dominant_flag,
                                  bus_overtemp_flag, bus_overcurrent_flag};
    wire        bus_fault = |bus_phy_status;
    wire        receive_only = bus_phy_control_reg[lpcs_pkg::RX_ONLY_BIT];
    wire        bus_pullup_enable = mode_control_reg[lpcs_pkg::PULLUP_BIT];
    wire        bus_irq_mask = interrupt_mask_reg[lpcs_pkg::BUS_MASK_BIT];

    // current operating mode decoded from mode bits
    function automatic lpcs_pkg::lpcs_mode_e mode_of(input logic [1:0] m);
        case (m)
            2'h1:    mode_of = lpcs_pkg::LPCS_STOP;
            2'h2:    mode_of = lpcs_pkg::LPCS_SLEEP;
            2'h3:    mode_of = lpcs_pkg::LPCS_NWDC;
            default: mode_of = lpcs_pkg::LPCS_NORMAL;
        endcase
    endfunction : mode_of
    lpcs_pkg::lpcs_mode_e cur_mode;
    assign cur_mode = mode_of(mode_control_reg[lpcs_pkg::MODE_MSB:0]);
    wire low_power = (cur_mode == lpcs_pkg::LPCS_STOP) || (cur_mode == lpcs_pkg::LPCS_SLEEP);

    // spi shift engine
    logic [7:0] rx_sh_reg;                 // incoming bits, msb first
    logic [7:0] tx_sh_reg;                 // outgoing bits
    logic [3:0] edge_cnt_reg;              // sampling edges seen, saturates
    logic       frame_ok;                  // exactly eight sample edges
    assign frame_ok = (edge_cnt_reg == 4'(lpcs_pkg::FRAME_BITS));

    // read data chosen at chip select fall
    wire [3:0] rd_addr = rx_sh_reg[lpcs_pkg::ADDR_MSB:lpcs_pkg::ADDR_LSB];
    wire [3:0] summary = {|volt_flags[3:1] | power_loss_flag, bus_fault,
                          hs_summary, ls_summary};
    wire [3:0] volt_stat = {volt_flags[3:1], power_loss_flag};

    // fifo carries committed frames to the register update logic
    wire [7:0] fifo_out;
    wire       fifo_valid;
    wire       fifo_in_ready;
    wire       fifo_push = cs_rise && frame_ok;
    logic      fifo_take;
    lpcs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_data   (rx_sh_reg),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );
    // drain one frame per cycle except while a status read is being snapped
    assign fifo_take = fifo_valid && !cs_fall;
    wire [3:0] wr_addr = fifo_out[7:4];
    wire [3:0] wr_data = fifo_out[3:0];
    wire       wr_any  = fifo_take;
    // status register read: frame addressed at 4 or 5 reached commit
    wire       stat_read = wr_any && (wr_addr == lpcs_pkg::ADDR_BUS_CTRL ||
                                      wr_addr == lpcs_pkg::ADDR_BUS_STAT);

    // shift register and miso, launch on rise, sample on fall
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_reg    <= 8'h00;
            tx_sh_reg    <= 8'h00;
            edge_cnt_reg <= 4'h0;
            miso_o       <= 1'b0;
            miso_oe      <= 1'b0;
        end else if (cs_fall) begin
            // capture read data using the previous frame address
            tx_sh_reg    <= {summary, rd_status(rd_addr)};
            edge_cnt_reg <= 4'h0;
            miso_oe      <= 1'b1;
            miso_o       <= summary[3];
        end else if (cs_rise) begin
            miso_oe      <= 1'b0;
        end else begin
            if (sclk_rise) begin
                miso_o    <= tx_sh_reg[7];
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
            if (sclk_fall) begin
                rx_sh_reg <= {rx_sh_reg[6:0], mosi_s};
                if (edge_cnt_reg != 4'hf) edge_cnt_reg <= edge_cnt_reg + 4'h1;
            end
        end
    end

    // register status nibble by address
    function automatic logic [3:0] rd_status(input logic [3:0] a);
        case (a)
            4'h0, 4'h1: rd_status = volt_stat;
            4'h4, 4'h5: rd_status = bus_phy_status;
            4'he, 4'hf: rd_status = interrupt_source_reg;
            default:    rd_status = 4'h0;
        endcase
    endfunction : rd_status

    // control register writes, soft reset restores defaults
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_phy_control_reg <= lpcs_pkg::BUS_CTRL_RST;
            mode_control_reg    <= lpcs_pkg::MODE_CTRL_RST;
            interrupt_mask_reg  <= lpcs_pkg::IRQ_MASK_RST;
        end else if (soft_rst) begin
            bus_phy_control_reg <= lpcs_pkg::BUS_CTRL_RST;
            mode_control_reg    <= lpcs_pkg::MODE_CTRL_RST;
            interrupt_mask_reg  <= lpcs_pkg::IRQ_MASK_RST;
        end else begin
            if (wr_any && wr_addr == lpcs_pkg::ADDR_BUS_CTRL)
                bus_phy_control_reg <= wr_data;
            else if (bus_fault && cur_mode == lpcs_pkg::LPCS_NORMAL)
                bus_phy_control_reg[lpcs_pkg::RX_ONLY_BIT] <= 1'b1;
            if (wr_any && wr_addr == lpcs_pkg::ADDR_MODE_CTRL)
                mode_control_reg <= wr_data;
            if (wr_any && wr_addr == lpcs_pkg::ADDR_IRQ_MASK)
                interrupt_mask_reg <= wr_data;
        end
    end

    // power loss flag: set at power-on only, cleared by mode/voltage access
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_loss_flag <= 1'b1;
        end else if (wr_any && (wr_addr == lpcs_pkg::ADDR_MODE_CTRL ||
                                wr_addr == lpcs_pkg::ADDR_VOLT_STAT)) begin
            power_loss_flag <= 1'b0;
        end
    end

    // stuck dominant timer on txd
    logic [31:0] dom_cnt_reg;              // cycles txd has been low
    wire         dom_expired = (dom_cnt_reg >= 32'(TX_DOM_CYC));
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) dom_cnt_reg <= 32'h0;
        else if (txd_s) dom_cnt_reg <= 32'h0;
        else if (!dom_expired) dom_cnt_reg <= dom_cnt_reg + 32'h1;
    end

    // rxd short check: readback lags the drive by the synchroniser, so use the level two back
    logic [1:0] rxd_drv_hist_reg;          // drive level one and two cycles back
    wire        rxd_short = (rxd_drv_hist_reg[1] != rxfb_s) &&
                            (rxd_drv_hist_reg[1] == rxd_drv_hist_reg[0]);
    // fault flags and transmitter hold-offs; set wins over read clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_overcurrent_flag   <= 1'b0;
            bus_overtemp_flag      <= 1'b0;
            rx_pin_short_flag      <= 1'b0;
            tx_stuck_dominant_flag <= 1'b0;
            ot_off_reg             <= 1'b0;
            rs_off_reg             <= 1'b0;
            td_off_reg             <= 1'b0;
        end else if (soft_rst) begin
            bus_overcurrent_flag   <= 1'b0;
            bus_overtemp_flag      <= 1'b0;
            rx_pin_short_flag      <= 1'b0;
            tx_stuck_dominant_flag <= 1'b0;
            ot_off_reg             <= 1'b0;
            rs_off_reg             <= 1'b0;
            td_off_reg             <= 1'b0;
        end else begin
            // over-current only flags, cleared by status read when gone
            if (oc_s) bus_overcurrent_flag <= 1'b1;
            else if (stat_read) bus_overcurrent_flag <= 1'b0;
            // over-temperature
            if (ot_s) begin
                bus_overtemp_flag <= 1'b1;
                ot_off_reg        <= 1'b1;
            end else if (txd_s && (ot_off_reg || stat_read)) begin
                ot_off_reg        <= 1'b0;
                if (stat_read) bus_overtemp_flag <= 1'b0;
            end
            // rxd short: driven level differs from readback
            if (rxd_short) begin
                rx_pin_short_flag <= 1'b1;
                rs_off_reg        <= 1'b1;
            end else begin
                if (rs_off_reg && rx_toggle && txd_s) rs_off_reg <= 1'b0;
                if (stat_read) rx_pin_short_flag <= 1'b0;
            end
            // stuck dominant txd
            if (dom_expired) begin
                tx_stuck_dominant_flag <= 1'b1;
                td_off_reg             <= 1'b1;
            end else if (txd_s) begin
                td_off_reg <= 1'b0;
                if (stat_read) tx_stuck_dominant_flag <= 1'b0;
            end
        end
    end

    // wake detection: dominant longer than filter time, then rising edge
    logic [15:0] wk_cnt_reg;               // dominant duration counter
    wire         wk_long = (wk_cnt_reg >= 16'(lpcs_pkg::WAKE_FILT_CYCLES));
    wire         wake_en = low_power && !receive_only;
    wire         wake_ev = wake_en && wk_long && bus_rise;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) wk_cnt_reg <= 16'h0;
        else if (bus_s || !wake_en) wk_cnt_reg <= 16'h0;
        else if (!wk_long) wk_cnt_reg <= wk_cnt_reg + 16'h1;
    end

    // interrupt source: wake recorded, read clears unless set again
    wire ws_read = wr_any && (wr_addr == lpcs_pkg::ADDR_IRQ_MASK ||
                              wr_addr == lpcs_pkg::ADDR_IRQ_SRC);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) interrupt_source_reg <= 4'h0;
        else if (wake_ev) interrupt_source_reg[lpcs_pkg::BUS_MASK_BIT] <= 1'b1;
        else if (ws_read) interrupt_source_reg <= 4'h0;
    end

    // registered pin outputs
    wire tx_block = receive_only || low_power || ot_off_reg || rs_off_reg || td_off_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_drive              <= 1'b0;
            rxd_o                 <= 1'b1;
            rxd_drv_hist_reg      <= 2'h3;
            slew_rate_select      <= lpcs_pkg::SLEW_20K;
            dominant_level_select <= 1'b0;
            pullup_on             <= 1'b1;
            bus_wake_threshold    <= 1'b1;
            irq_n                 <= 1'b1;
            wake_reset_req        <= 1'b0;
        end else begin
            tx_drive   <= !txd_s && !tx_block;
            // stop mode with receive-only mirrors the bus; normal mode always does
            rxd_o      <= (cur_mode == lpcs_pkg::LPCS_SLEEP) ? 1'b1 :
                          (low_power && !receive_only) ? 1'b1 : bus_s;
            rxd_drv_hist_reg <= {rxd_drv_hist_reg[0], rxd_o};
            slew_rate_select      <= bus_phy_control_reg[1:0];
            dominant_level_select <= bus_phy_control_reg[lpcs_pkg::DOM_LVL_BIT];
            pullup_on          <= !low_power || bus_pullup_enable;
            bus_wake_threshold <= bus_pullup_enable;
            irq_n <= !((bus_fault && bus_irq_mask) ||
                       (interrupt_source_reg[lpcs_pkg::BUS_MASK_BIT] && bus_irq_mask));
            wake_reset_req <= wake_ev && (cur_mode == lpcs_pkg::LPCS_SLEEP);
        end
    end
endmodule : lpcs_top
`default_nettype wire

// [sim/lpcs_chk.sv]
// lpcs_chk: port checks for lpcs_top.
// assumes the bind below; inputs sync 2 ff, so waits exceed that lag.
`timescale 1ns/10ps
`default_nettype none
module lpcs_chk (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       miso_o,
    input wire logic       miso_oe,
    input wire logic       otemp_det,
    input wire logic       tx_drive,
    input wire logic       pullup_on,
    input wire logic       irq_n,
    input wire logic       wake_reset_req,
    input wire logic [1:0] slew_rate_select
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_oe_idle_off: assert property (cs_n [*8] |-> !miso_oe) else $error("miso on");
    a_oe_sel_on: assert property (!cs_n [*8] |-> miso_oe) else $error("miso off");
    a_otemp_tx_off: assert property (otemp_det [*6] |-> !tx_drive) else $error("tx on");
    a_slew_rst_val: assert property ($rose(rst_n) |-> slew_rate_select == 2'h0)
        else $error("slew rst");
    a_pullup_rst_on: assert property ($rose(rst_n) |-> pullup_on) else $error("pu rst");
    a_irq_rst_idle: assert property ($rose(rst_n) |-> irq_n) else $error("irq rst");
    a_miso_bit_holds: assert property ((!cs_n && $stable(sclk) && $stable(cs_n)) [*5]
        |=> $stable(miso_o)) else $error("miso moved");
    a_wake_one_cycle: assert property (wake_reset_req |=> !wake_reset_req)
        else $error("wake long");
    c_frame: cover property (!miso_oe ##1 miso_oe);
    c_irq: cover property (!irq_n);
    c_pullup_off: cover property (!pullup_on);
endmodule : lpcs_chk
bind lpcs_top lpcs_chk u_chk (.*);
`default_nettype wire

// [sim/lpcs_host.sv]
// lpcs_host: behavioural spi master for lpcs_top.
// assumes sclk phases far longer than the device's synchronisers.
`timescale 1ns/10ps
`default_nettype none
module lpcs_host (
    input  wire logic core_clk,
    input  wire logic miso_o,
    output logic      cs_n = 1'b1,
    output logic      sclk = 1'b0,
    output logic      mosi = 1'b0
);
    // n sclk pulses msb first; sclk idles low between frames
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        @(posedge core_clk) cs_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b1;
            mosi <= tx[7-i];
            repeat (6) @(posedge core_clk);
            sclk <= 1'b0;
            rx = {rx[6:0], miso_o};
            repeat (6) @(posedge core_clk);
        end
        cs_n <= 1'b1;
        mosi <= ~mosi; // released line must not show the last bit
        repeat (12) @(posedge core_clk);
    endtask : xfer
endmodule : lpcs_host
`default_nettype wire

// [sim/test_lin_phy_control_spi_port.sv]
// test_lin_phy_control_spi_port: frame-level test of lpcs_top.
// assumes lpcs_host drives spi and lpcs_chk binds itself.
`timescale 1ns/10ps
`default_nettype none
module test_lin_phy_control_spi_port;
    logic       core_clk = 0, rst_n = 0, ext_rst_n = 1, txd = 1, ocur_det = 0, otemp_det = 0;
    logic       hs_summary = 0, cs_n, sclk, mosi, miso_o, dom_lvl, pullup_on, irq_n;
    logic       tx_drv, wake_req, wake_thr, seen;
    wire        rxd_loop;
    logic [1:0] slew;
    logic [7:0] rx;
    int         n_errors = 0, compares = 0;
    initial forever #50 core_clk = ~core_clk;
    lpcs_host host (.core_clk(core_clk), .miso_o(miso_o), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
    // bus_rx follows txd, as a quiet bus would; rxd_fb reads the rxd drive back
    lpcs_top #(.TX_DOM_CYC(50)) DUT (.core_clk(core_clk), .rst_n(rst_n), .ext_rst_n(ext_rst_n),
        .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso_o(miso_o), .miso_oe(), .txd(txd),
        .bus_rx(txd), .rxd_fb(rxd_loop), .ocur_det(ocur_det), .otemp_det(otemp_det),
        .volt_flags(4'h0), .hs_summary(hs_summary), .ls_summary(1'b0), .rxd_o(rxd_loop),
        .tx_drive(tx_drv), .slew_rate_select(slew), .dominant_level_select(dom_lvl),
        .pullup_on(pullup_on), .bus_wake_threshold(wake_thr), .irq_n(irq_n),
        .wake_reset_req(wake_req));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask : chk
    task automatic report_and_stop;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("slew", 8'h0, {6'h0, slew});
        for (int k = 0; k < 3; k++) begin
            host.xfer({6'h12, k[1:0]}, 8, rx);
            chk("slew", k[7:0], {6'h0, slew});
            chk("dom", 8'h1, {7'h0, dom_lvl});
        end
        txd <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("drive", 8'h1, {7'h0, tx_drv});
        repeat (60) @(posedge core_clk);
        chk("drive", 8'h0, {7'h0, tx_drv});
        txd <= 1'b1;
        host.xfer(8'h40, 7, rx);
        chk("short", 8'h2, {6'h0, slew});
        host.xfer(8'he2, 8, rx);
        ocur_det <= 1'b1;
        otemp_det <= 1'b1;
        hs_summary <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk("irq", 8'h0, {7'h0, irq_n});
        host.xfer(8'h50, 8, rx);
        host.xfer(8'h50, 8, rx);
        chk("reply", 8'he3, rx);
        ocur_det <= 1'b0;
        otemp_det <= 1'b0;
        host.xfer(8'h01, 8, rx);
        chk("pullup", 8'h0, {7'h0, pullup_on});
        chk("wake thr", 8'h0, {7'h0, wake_thr});
        ext_rst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        ext_rst_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk("slew", 8'h0, {6'h0, slew});
        chk("pullup", 8'h1, {7'h0, pullup_on});
        host.xfer(8'h06, 8, rx);
        txd <= 1'b0;
        repeat (330) @(posedge core_clk);
        txd <= 1'b1;
        seen = 1'b0;
        repeat (8) @(posedge core_clk) seen |= wake_req;
        chk("wake", 8'h1, {7'h0, seen});
        report_and_stop();
    end
endmodule : test_lin_phy_control_spi_port
`default_nettype wire
